//--- src/crtrt_pkg.sv
// Package for the raster timing, cursor and light-pen block.
// Assumes an AHB-Lite slave with one 32-bit word per register.
package crtrt_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [4:0] IDX_HTOTAL = 5'h00;
  localparam logic [4:0] IDX_HDISP = 5'h01;
  localparam logic [4:0] IDX_HSYNC_POS = 5'h02;
  localparam logic [4:0] IDX_SYNC_WID = 5'h03;
  localparam logic [4:0] IDX_VTOTAL = 5'h04;
  localparam logic [4:0] IDX_VADJ = 5'h05;
  localparam logic [4:0] IDX_VDISP = 5'h06;
  localparam logic [4:0] IDX_VSYNC_POS = 5'h07;
  localparam logic [4:0] IDX_ILACE = 5'h08;
  localparam logic [4:0] IDX_CHAR_VT = 5'h09;
  localparam logic [4:0] IDX_CUR_START = 5'h0A;
  localparam logic [4:0] IDX_CUR_END = 5'h0B;
  localparam logic [4:0] IDX_DSTART_HI = 5'h0C;
  localparam logic [4:0] IDX_DSTART_LO = 5'h0D;
  localparam logic [4:0] IDX_CUR_HI = 5'h0E;
  localparam logic [4:0] IDX_CUR_LO = 5'h0F;
  localparam logic [4:0] IDX_PEN_ROW = 5'h10;
  localparam logic [4:0] IDX_PEN_COL = 5'h11;
  localparam logic [4:0] IDX_STATUS = 5'h12;
  localparam logic [4:0] IDX_MODE = 5'h13;
  localparam int NUM_REGS = 20;
  localparam int NUM_RW = 16;
  // Field positions
  localparam int STATUS_PEN_BIT = 6;
  localparam int MODE_BITMAP_BIT = 0;
  localparam int BLINK16_BIT = 3;
  localparam int BLINK32_BIT = 4;
  // Light-pen count origins
  localparam logic [7:0] PEN_ROW_BASE = 8'h01;
  localparam logic [7:0] PEN_COL_BASE = 8'h08;
  // Reset values of the timing registers (80x25, 8x8 cells)
  localparam logic [7:0] RST_HTOTAL = 8'h63;
  localparam logic [7:0] RST_HDISP = 8'h50;
  localparam logic [7:0] RST_HSYNC_POS = 8'h55;
  localparam logic [7:0] RST_SYNC_WID = 8'h49;
  localparam logic [7:0] RST_VTOTAL = 8'h1F;
  localparam logic [7:0] RST_VADJ = 8'h00;
  localparam logic [7:0] RST_VDISP = 8'h19;
  localparam logic [7:0] RST_VSYNC_POS = 8'h1D;
  localparam logic [7:0] RST_CHAR_VT = 8'h07;
  localparam logic [7:0] RST_CUR_START = 8'h20;
  localparam logic [7:0] RST_CUR_END = 8'h08;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    CRTRT_CUR_STEADY = 2'b00,
    CRTRT_CUR_OFF = 2'b01,
    CRTRT_CUR_BLINK16 = 2'b10,
    CRTRT_CUR_BLINK32 = 2'b11
  } crtrt_cursor_mode_type;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic display_en;
    logic cursor_on;
    logic odd_field;
  } crtrt_video_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [4:0] line;
    logic bitmap;
  } crtrt_fetch_type;

  typedef struct packed {
    logic [3:0] fg;
    logic [3:0] bg;
  } crtrt_attr_type;
endpackage

//--- src/crtrt_top.sv
// Raster timing generator with cursor and light pen, AHB-Lite slave.
// Assumes pen_strobe_input is asynchronous; everything else is on hclk.
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module crtrt_top #(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pen_strobe_input,
  input wire logic [7:0] attr_byte,
  output crtrt_pkg::crtrt_video_type video,
  output crtrt_pkg::crtrt_fetch_type fetch,
  output crtrt_pkg::crtrt_attr_type attr_colors
);
  initial begin
    if (ADDR_W < 8) $error("crtrt_top: ADDR_W must reach all registers");
  end

  // Register bank
  logic [7:0] regs_reg [crtrt_pkg::NUM_RW];
  logic [7:0] mode_reg;
  logic [7:0] pen_row_reg;
  logic [7:0] pen_col_reg;
  logic pen_valid_reg;

  localparam logic [7:0] RST_VALS [crtrt_pkg::NUM_RW] = '{
    crtrt_pkg::RST_HTOTAL, crtrt_pkg::RST_HDISP, crtrt_pkg::RST_HSYNC_POS,
    crtrt_pkg::RST_SYNC_WID, crtrt_pkg::RST_VTOTAL, crtrt_pkg::RST_VADJ,
    crtrt_pkg::RST_VDISP, crtrt_pkg::RST_VSYNC_POS, crtrt_pkg::RST_ZERO,
    crtrt_pkg::RST_CHAR_VT, crtrt_pkg::RST_CUR_START, crtrt_pkg::RST_CUR_END,
    crtrt_pkg::RST_ZERO, crtrt_pkg::RST_ZERO, crtrt_pkg::RST_ZERO,
    crtrt_pkg::RST_ZERO};

  // AHB address phase capture
  logic wr_pend_reg;
  logic [4:0] wr_idx_reg;
  wire addr_ok = haddr[1:0] == 2'b00 && haddr[ADDR_W-1:7] == '0;
  wire [4:0] a_idx = haddr[6:2];
  wire take = hsel && hready && htrans == crtrt_pkg::HTRANS_NONSEQ;
  wire take_wr = take && hwrite && addr_ok;
  wire take_rd = take && !hwrite && addr_ok;
  wire pen_read = take_rd &&
    (a_idx == crtrt_pkg::IDX_PEN_ROW || a_idx == crtrt_pkg::IDX_PEN_COL);

  // A read right behind a write to the same register sees the new value
  wire fwd_ok = wr_pend_reg && wr_idx_reg == a_idx &&
    (a_idx < 5'(crtrt_pkg::NUM_RW) || a_idx == crtrt_pkg::IDX_MODE);
  wire [7:0] rd_byte = fwd_ok ? hwdata[7:0] : rd_val;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Read mux, registered into the data phase
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (a_idx < 5'(crtrt_pkg::NUM_RW)) begin
      rd_val = regs_reg[a_idx[3:0]];
    end else begin
      case (a_idx)
        crtrt_pkg::IDX_PEN_ROW: rd_val = pen_row_reg;
        crtrt_pkg::IDX_PEN_COL: rd_val = pen_col_reg;
        crtrt_pkg::IDX_STATUS: rd_val = {1'b0, pen_valid_reg, 6'h00};
        crtrt_pkg::IDX_MODE: rd_val = mode_reg;
        default: rd_val = 8'h00;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 5'h00;
    end else begin
      hrdata <= take_rd ? {24'h000000, rd_byte} : 32'h00000000;
      wr_pend_reg <= take_wr;
      wr_idx_reg <= a_idx;
    end
  end

  for (genvar g = 0; g < crtrt_pkg::NUM_RW; g++) begin : g_regs
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        regs_reg[g] <= RST_VALS[g];
      end else if (wr_pend_reg && wr_idx_reg == 5'(g)) begin
        regs_reg[g] <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= crtrt_pkg::RST_ZERO;
    end else if (wr_pend_reg && wr_idx_reg == crtrt_pkg::IDX_MODE) begin
      mode_reg <= hwdata[7:0];
    end
  end

  // Field views
  wire [7:0] h_total = regs_reg[crtrt_pkg::IDX_HTOTAL[3:0]];
  wire [7:0] h_disp = regs_reg[crtrt_pkg::IDX_HDISP[3:0]];
  wire [7:0] h_spos = regs_reg[crtrt_pkg::IDX_HSYNC_POS[3:0]];
  wire [3:0] h_swid = regs_reg[crtrt_pkg::IDX_SYNC_WID[3:0]][3:0];
  wire [3:0] v_swid = regs_reg[crtrt_pkg::IDX_SYNC_WID[3:0]][7:4];
  wire [7:0] v_total = regs_reg[crtrt_pkg::IDX_VTOTAL[3:0]];
  wire [4:0] v_adj = regs_reg[crtrt_pkg::IDX_VADJ[3:0]][4:0];
  wire [7:0] v_disp = regs_reg[crtrt_pkg::IDX_VDISP[3:0]];
  wire [7:0] v_spos = regs_reg[crtrt_pkg::IDX_VSYNC_POS[3:0]];
  wire [1:0] ilace = regs_reg[crtrt_pkg::IDX_ILACE[3:0]][1:0];
  wire [4:0] char_vt = regs_reg[crtrt_pkg::IDX_CHAR_VT[3:0]][4:0];
  wire [4:0] cur_start = regs_reg[crtrt_pkg::IDX_CUR_START[3:0]][4:0];
  wire [1:0] cur_mode_bits = regs_reg[crtrt_pkg::IDX_CUR_START[3:0]][6:5];
  wire [4:0] cur_end = regs_reg[crtrt_pkg::IDX_CUR_END[3:0]][4:0];
  wire [15:0] disp_start = {regs_reg[crtrt_pkg::IDX_DSTART_HI[3:0]],
    regs_reg[crtrt_pkg::IDX_DSTART_LO[3:0]]};
  wire [15:0] cur_addr = {regs_reg[crtrt_pkg::IDX_CUR_HI[3:0]],
    regs_reg[crtrt_pkg::IDX_CUR_LO[3:0]]};
  crtrt_pkg::crtrt_cursor_mode_type cur_mode;
  assign cur_mode = crtrt_pkg::crtrt_cursor_mode_type'(cur_mode_bits);
  wire ilace_sync = ilace[0];
  wire ilace_video = ilace == 2'b11;

  // Counters
  logic [7:0] hcnt_reg;
  logic [7:0] row_reg;
  logic [4:0] line_reg;
  logic [4:0] adj_cnt_reg;
  logic in_adj_reg;
  logic odd_reg;
  logic [4:0] frame_cnt_reg;
  logic [15:0] row_addr_reg;
  logic [15:0] char_addr_reg;
  logic [3:0] hs_cnt_reg;
  logic hsync_reg;
  logic [4:0] vs_cnt_reg;
  logic vsync_reg;
  logic vs_arm_reg;

  wire line_end = hcnt_reg == h_total;
  wire half_line = hcnt_reg == {1'b0, h_total[7:1]};
  // Sync-and-video steps two lines per field, shifted by field parity
  wire [4:0] line_step = ilace_video ? 5'h02 : 5'h01;
  wire [4:0] line_first = (ilace_video && odd_reg) ? 5'h01 : 5'h00;
  wire row_last_line = line_reg + line_step > char_vt;
  wire [4:0] adj_lim = ilace_video ? {1'b0, v_adj[4:1]} : v_adj;
  wire [4:0] vs_lim = ilace_video ? {2'b00, v_swid[3:1]} : {1'b0, v_swid};
  wire rows_done = row_reg == v_total;
  wire frame_end = line_end && (in_adj_reg ? adj_cnt_reg + 5'h01 >= adj_lim
    : (row_last_line && rows_done && adj_lim == 5'h00));
  wire h_active = hcnt_reg < h_disp;
  wire v_active = !in_adj_reg && row_reg < v_disp;
  wire row_hit = !in_adj_reg && row_reg + 8'h01 == v_spos - 8'h01;
  // Odd fields of interlaced sync start vsync mid-line
  wire odd_half = ilace_sync && odd_reg && !ilace_video;
  wire vs_start = odd_half ?
    (vs_arm_reg && half_line) : (row_hit && line_end && row_last_line);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hcnt_reg <= 8'h00;
      row_reg <= 8'h00;
      line_reg <= 5'h00;
      adj_cnt_reg <= 5'h00;
      in_adj_reg <= 1'b0;
      odd_reg <= 1'b0;
      row_addr_reg <= 16'h0000;
      char_addr_reg <= 16'h0000;
    end else begin
      hcnt_reg <= line_end ? 8'h00 : hcnt_reg + 8'h01;
      if (h_active && v_active) begin
        char_addr_reg <= char_addr_reg + 16'h0001;
      end else if (line_end) begin
        char_addr_reg <= row_addr_reg;
      end
      if (frame_end) begin
        row_reg <= 8'h00;
        line_reg <= (ilace_video && !odd_reg) ? 5'h01 : 5'h00;
        in_adj_reg <= 1'b0;
        adj_cnt_reg <= 5'h00;
        odd_reg <= ilace_sync ? !odd_reg : 1'b0;
        row_addr_reg <= disp_start;
        char_addr_reg <= disp_start;
      end else if (line_end) begin
        if (in_adj_reg) begin
          adj_cnt_reg <= adj_cnt_reg + 5'h01;
        end else if (row_last_line) begin
          line_reg <= line_first;
          if (rows_done) begin
            in_adj_reg <= 1'b1;
          end else begin
            row_reg <= row_reg + 8'h01;
          end
          if (v_active) begin
            // Bitmap mode advances per scan line, character mode per row
            row_addr_reg <= row_addr_reg + {8'h00, h_disp};
            char_addr_reg <= row_addr_reg + {8'h00, h_disp};
          end
        end else begin
          line_reg <= line_reg + line_step;
          if (mode_reg[crtrt_pkg::MODE_BITMAP_BIT] && v_active) begin
            row_addr_reg <= row_addr_reg + {8'h00, h_disp};
            char_addr_reg <= row_addr_reg + {8'h00, h_disp};
          end
        end
      end
    end
  end

  // Sync generation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_cnt_reg <= 4'h0;
      hsync_reg <= 1'b0;
      vs_cnt_reg <= 5'h00;
      vsync_reg <= 1'b0;
      vs_arm_reg <= 1'b0;
      frame_cnt_reg <= 5'h00;
    end else begin
      if (hcnt_reg == h_spos) begin
        hsync_reg <= 1'b1;
        hs_cnt_reg <= h_swid;
      end else if (hsync_reg) begin
        if (hs_cnt_reg == 4'h0) begin
          hsync_reg <= 1'b0;
        end else begin
          hs_cnt_reg <= hs_cnt_reg - 4'h1;
        end
      end
      // Arm only for the half-line start, so no stale arm fires early
      if (odd_half && row_hit && line_end && row_last_line) begin
        vs_arm_reg <= 1'b1;
      end else if (vs_start || !odd_half) begin
        vs_arm_reg <= 1'b0;
      end
      // Vsync counts whole lines, so it carries across the frame boundary
      if (vs_start && vs_lim != 5'h00) begin
        vsync_reg <= 1'b1;
        vs_cnt_reg <= vs_lim;
        frame_cnt_reg <= frame_cnt_reg + 5'h01;
      end else if (vsync_reg && (ilace_sync && odd_reg && !ilace_video ?
          half_line : line_end)) begin
        if (vs_cnt_reg <= 5'h01) begin
          vsync_reg <= 1'b0;
        end
        vs_cnt_reg <= vs_cnt_reg - 5'h01;
      end
    end
  end

  // Cursor
  wire on_cursor_line = line_reg >= cur_start && line_reg + 5'h01 < cur_end + 5'h01 &&
    line_reg < cur_end;
  logic blink_ok;
  always_comb begin
    case (cur_mode)
      crtrt_pkg::CRTRT_CUR_STEADY: blink_ok = 1'b1;
      crtrt_pkg::CRTRT_CUR_OFF: blink_ok = 1'b0;
      crtrt_pkg::CRTRT_CUR_BLINK16: blink_ok = frame_cnt_reg[crtrt_pkg::BLINK16_BIT];
      crtrt_pkg::CRTRT_CUR_BLINK32: blink_ok = frame_cnt_reg[crtrt_pkg::BLINK32_BIT];
      default: blink_ok = 1'b0;
    endcase
  end
  wire cursor_now = h_active && v_active && char_addr_reg == cur_addr &&
    on_cursor_line && blink_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      video <= '0;
      fetch <= '0;
      attr_colors <= '0;
    end else begin
      video <= '{hsync: hsync_reg, vsync: vsync_reg, display_en: h_active && v_active,
        cursor_on: cursor_now, odd_field: odd_reg};
      fetch <= '{addr: char_addr_reg, line: line_reg,
        bitmap: mode_reg[crtrt_pkg::MODE_BITMAP_BIT]};
      attr_colors <= '{fg: attr_byte[3:0], bg: attr_byte[7:4]};
    end
  end

  // Light pen: two-stage synchroniser then edge detect on stage two
  logic pen_s1_reg;
  logic pen_s2_reg;
  logic pen_s3_reg;
  wire pen_rise = pen_s2_reg && !pen_s3_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pen_s1_reg <= 1'b0;
      pen_s2_reg <= 1'b0;
      pen_s3_reg <= 1'b0;
      pen_row_reg <= 8'h00;
      pen_col_reg <= 8'h00;
      pen_valid_reg <= 1'b0;
    end else begin
      pen_s1_reg <= pen_strobe_input;
      pen_s2_reg <= pen_s1_reg;
      pen_s3_reg <= pen_s2_reg;
      if (pen_rise) begin
        pen_row_reg <= row_reg + crtrt_pkg::PEN_ROW_BASE;
        pen_col_reg <= hcnt_reg + crtrt_pkg::PEN_COL_BASE;
      end
      // Set wins over a same-cycle read
      if (pen_rise) begin
        pen_valid_reg <= 1'b1;
      end else if (pen_read) begin
        pen_valid_reg <= 1'b0;
      end
    end
  end
endmodule

//--- tb/crtrt_pen_model.sv
// Light pen and display memory stand-in facing the raster block.
// Assumes the bench arms it; the pen fires on the chosen display line.
`timescale 1ns/10ps
module crtrt_pen_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire crtrt_pkg::crtrt_video_type video,
  input wire logic arm,
  input wire logic [7:0] line_no,
  output logic pen_strobe_input,
  output logic [7:0] attr_byte
);
  logic de_q, vs_q;
  logic [7:0] lines;
  logic [4:0] dwell;
  logic [3:0] hold;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {de_q, vs_q, lines, dwell, hold, pen_strobe_input} <= '0;
      attr_byte <= 8'h5A;
    end else begin
      {de_q, vs_q} <= {video.display_en, video.vsync};
      // Memory data moves every cycle so stale nibbles show up
      attr_byte <= attr_byte + 8'h3B;
      if (video.vsync && !vs_q) lines <= 8'h00;
      else if (video.display_en && !de_q) lines <= lines + 8'h01;
      dwell <= (video.display_en && !de_q) ? 5'h1 : dwell + {4'h0, dwell != 5'h1F};
      if (arm && hold == 4'h0 && lines == line_no && dwell == 5'h4) begin
        pen_strobe_input <= 1'b1;
        hold <= 4'hA;
      end else if (hold != 4'h0) begin
        hold <= hold - 4'h1;
        pen_strobe_input <= hold != 4'h1;
      end
    end
  end
endmodule

//--- tb/crtrt_props.sv
// Checker for the raster outputs of crtrt_top.
// Assumes one character per hclk; shadows timing registers from bus writes.
`timescale 1ns/10ps
module crtrt_props #(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [7:0] attr_byte,
  input wire crtrt_pkg::crtrt_video_type video,
  input wire crtrt_pkg::crtrt_fetch_type fetch,
  input wire crtrt_pkg::crtrt_attr_type attr_colors
);
  logic [7:0] sh [16];
  logic [3:0] wa;
  logic wp, progd, hs_q, vs_q, de_q;
  logic [11:0] since;
  logic [15:0] hc, hw, dn, vw, dl;
  logic [31:0] fc;
  // Only judged after the timing ran unchanged for several frames
  wire quiet = since == 12'hFFF && progd && !sh[8][0];
  wire [15:0] ht1 = {8'h00, sh[0]} + 16'h1;
  wire [15:0] cv1 = {11'h0, sh[9][4:0]} + 16'h1;
  wire [31:0] fexp = (({24'h0, sh[4]} + 32'h1) * {16'h0, cv1} + {27'h0, sh[5][4:0]}) * {16'h0, ht1};
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wp, progd, hs_q, vs_q, de_q, wa, since, hc, hw, dn, vw, dl, fc} <= '0;
      for (int i = 0; i < 16; i++) sh[i] <= 8'h00;
    end else begin
      wp <= hsel && hready && htrans == 2'h2 && hwrite && haddr[1:0] == 2'h0 && haddr[ADDR_W-1:6] == '0;
      wa <= haddr[5:2];
      if (wp) begin
        sh[wa] <= hwdata[7:0];
        since <= '0;
        progd <= 1'b1;
      end else if (since != 12'hFFF) begin
        since <= since + 12'h1;
      end
      {hs_q, vs_q, de_q} <= {video.hsync, video.vsync, video.display_en};
      hc <= (video.hsync && !hs_q) ? 16'h1 : hc + 16'h1;
      hw <= video.hsync ? hw + 16'h1 : 16'h0;
      dn <= video.display_en ? dn + 16'h1 : 16'h0;
      vw <= video.vsync ? vw + 16'h1 : 16'h0;
      fc <= (video.vsync && !vs_q) ? 32'h1 : fc + 32'h1;
      dl <= (video.vsync && !vs_q) ? 16'h0 : dl + {15'h0, video.display_en && !de_q};
    end
  end
  hsync_period_a: assert property ($rose(video.hsync) && quiet |-> hc == ht1)
    else $error("hsync period wrong");
  row_width_a: assert property ($fell(video.display_en) && quiet |-> dn == {8'h00, sh[1]})
    else $error("displayed characters per row wrong");
  hsync_width_a: assert property ($fell(video.hsync) && quiet |-> hw == {12'h0, sh[3][3:0]} + 16'h1)
    else $error("hsync width wrong");
  vsync_width_a: assert property ($fell(video.vsync) && quiet |-> vw == {12'h0, sh[3][7:4]} * ht1)
    else $error("vsync width wrong");
  frame_period_a: assert property ($rose(video.vsync) && quiet |-> fc == fexp)
    else $error("frame period wrong");
  frame_lines_a: assert property ($rose(video.vsync) && quiet |-> dl == {8'h00, sh[6]} * cv1)
    else $error("displayed lines per frame wrong");
  cursor_lines_a: assert property (video.cursor_on && quiet |->
    fetch.line >= sh[10][4:0] && fetch.line < sh[11][4:0]) else $error("cursor outside its lines");
  cursor_off_a: assert property (quiet && sh[10][6:5] == 2'b01 |-> !video.cursor_on)
    else $error("cursor shown while disabled");
  attr_split_a: assert property ($past(hresetn) |-> attr_colors.fg == $past(attr_byte[3:0])
    && attr_colors.bg == $past(attr_byte[7:4])) else $error("attribute nibbles misplaced");
endmodule
bind crtrt_top crtrt_props #(.ADDR_W(ADDR_W)) props_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .attr_byte(attr_byte), .video(video), .fetch(fetch), .attr_colors(attr_colors));

//--- tb/test_crt_raster_timing_cursor_lightpen.sv
// Self-checking bench for crtrt_top with a light pen model.
// Assumes zero wait states; timing shrunk to 20 characters by 26 lines.
`timescale 1ns/10ps
module test_crt_raster_timing_cursor_lightpen;
  logic hclk, hresetn, hsel, hwrite, arm, hreadyout, hresp, pen;
  logic [7:0] haddr, line_no, attr_byte;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  crtrt_pkg::crtrt_video_type video;
  crtrt_pkg::crtrt_fetch_type fetch;
  crtrt_pkg::crtrt_attr_type attr_colors;
  logic vs_q = 0, de_q = 0, cu_q = 0;
  logic [1:0] fld = 0;
  int num_errors = 0, checks_done = 0, cur_n = 0, de_cyc = 0, cur_pos = 0, vs_run = 0, vs_w = 0;
  int c0;
  // Address, written value, expected read
  logic [23:0] rows [20] = '{24'h001313, 24'h040A0A, 24'h080D0D, 24'h0C2222,
    24'h100505, 24'h140202, 24'h180303, 24'h1C0505, 24'h200000, 24'h240303,
    24'h280101, 24'h2C0303, 24'h301212, 24'h343434, 24'h381212, 24'h3C3636,
    24'h40FF00, 24'h44FF00, 24'h4C0000, 24'h7CAA00};
  logic [1:0] modes [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
  int nfr [4] = '{32, 32, 4, 10};
  int ncur [4] = '{32, 32, 8, 0};
  logic [1:0] ilc [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
  int ilw [4] = '{40, 40, 40, 20};
  crtrt_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pen_strobe_input(pen), .attr_byte(attr_byte),
    .video(video), .fetch(fetch), .attr_colors(attr_colors));
  crtrt_pen_model pen_u (.hclk(hclk), .hresetn(hresetn), .video(video), .arm(arm),
    .line_no(line_no), .pen_strobe_input(pen), .attr_byte(attr_byte));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    vs_q <= video.vsync;
    de_q <= video.display_en;
    cu_q <= video.cursor_on;
    de_cyc <= (video.display_en && !de_q) ? 1 : de_cyc + 1;
    if (video.cursor_on === 1'b1) cur_n <= cur_n + 1;
    if (video.cursor_on && !cu_q) cur_pos <= de_cyc;
    vs_run <= (video.vsync === 1'b1) ? vs_run + 1 : 0;
    if (!video.vsync && vs_q) begin
      vs_w <= vs_run;
      fld <= {fld[0], video.odd_field};
    end
  end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= crtrt_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("MISMATCH at %0t: %h outside %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wait_vs(input int n);
    repeat (n) begin
      @(posedge hclk);
      while (!(video.vsync === 1'b1 && vs_q === 1'b0)) @(posedge hclk);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #1600000;
    num_errors++;
    summarize();
  end
  initial begin
    {hsel, hwrite, arm, haddr, htrans, hwdata, hresetn} = '0;
    hsize = 3'h2;
    line_no = 8'h05;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      bus(1'b1, rows[i][23:16], rows[i][15:8], rd);
      bus(1'b0, rows[i][23:16], 8'h00, rd);
      chk(rd, {24'h0, rows[i][7:0]});
    end
    wait_vs(10);
    // Blink counts over 32 frames do not depend on the counter's phase
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h28, {1'b0, modes[m], 5'h01}, rd);
      wait_vs(1);
      c0 = cur_n;
      wait_vs(nfr[m]);
      chk(32'(cur_n - c0), 32'(ncur[m]));
    end
    chk(32'(cur_pos), 32'h2);
    arm <= 1'b1;
    @(posedge hclk);
    while (pen !== 1'b1) @(posedge hclk);
    arm <= 1'b0;
    repeat (8) @(posedge hclk);
    bus(1'b0, 8'h48, 8'h00, rd);
    chk(rd & 32'h40, 32'h40);
    bus(1'b0, 8'h40, 8'h00, rd);
    chk(rd, 32'h2);
    bus(1'b0, 8'h48, 8'h00, rd);
    chk(rd & 32'h40, 32'h0);
    bus(1'b0, 8'h44, 8'h00, rd);
    chk_in(rd, 32'hB, 32'h10);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 8'h20, {6'h0, ilc[k]}, rd);
      wait_vs(4);
      chk(32'(vs_w), 32'(ilw[k]));
      if (ilc[k][0]) chk({31'h0, fld[1] ^ fld[0]}, 32'h1);
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h00, 8'h00, rd);
    chk(rd, {24'h0, crtrt_pkg::RST_HTOTAL});
    bus(1'b0, 8'h0C, 8'h00, rd);
    chk(rd, {24'h0, crtrt_pkg::RST_SYNC_WID});
    bus(1'b0, 8'h48, 8'h00, rd);
    chk(rd & 32'h40, 32'h0);
    summarize();
  end
endmodule
